// ===== design/boot_fmt_cfg.svh
`ifndef BOOT_FMT_CFG_SVH
`define BOOT_FMT_CFG_SVH

// ==================================================
// Clock and timing
`define CLK_HZ        100000000
`define BAUD_RATE     115200
`define CMD_TIMEOUT_S 5
`define BREAK_MIN_US  100
`define US_PER_S      1000000

// ==================================================
// Acknowledgment
`define ACK_BYTE0 8'h00
`define ACK_BYTE1 8'hCC
`define ACK_LEN   2'h2
`define ACK_GAP_BITS  11
`define ACK_GAP_SLACK 4

// ==================================================
// Format string layout
`define FMT_LEN   13
`define POS_B1    1
`define POS_CAP   2
`define POS_B3    3
`define POS_B7    7
`define POS_SIZE  10
`define FMT_B1    8'h17
`define FMT_B3    8'h28
`define FMT_B7    8'h02
`define FMT_FILL  8'h00

// ==================================================
// Capacity codes and their size bytes
`define CAP_0M5   8'hAC
`define CAP_4M    8'h30
`define CAP_8M    8'h34
`define CAP_16M   8'h3C
`define SIZE_0M5  8'h00
`define SIZE_4M   8'h04
`define SIZE_8M   8'h08
`define SIZE_16M  8'h10

// ==================================================
// Serial framing
`define UART_FRAME_BITS 4'h9
`define UART_STOP_LVL   1'b1

`endif

// ===== design/boot_fmt_pkg.sv
package boot_fmt_pkg;

	// ==================================================
	// Types
	typedef enum logic [2:0] {
		ST_SENSE    = 3'b000,
		ST_ACK_OPEN = 3'b001,
		ST_WAIT_CMD = 3'b011,
		ST_FORMAT   = 3'b010,
		ST_ACK_DONE = 3'b110,
		ST_NORMAL   = 3'b100
	} boot_state_t;

	typedef struct packed {
		logic       vld;
		logic [7:0] data;
	} rx_byte_t;

	typedef struct packed {
		logic       start;
		logic [7:0] data;
	} tx_req_t;

endpackage : boot_fmt_pkg

// ===== design/uart_byte_tx.sv
`include "boot_fmt_cfg.svh"

module uart_byte_tx #(
	parameter int CLKS_PER_BIT = `CLK_HZ / `BAUD_RATE
) (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire boot_fmt_pkg::tx_req_t req,
	output logic                       busy,
	output logic                       txd
);
	import boot_fmt_pkg::*;

	localparam int CW = $clog2(CLKS_PER_BIT + 1);

	logic [CW-1:0] baud_r;
	logic [3:0]    bit_r;
	logic [9:0]    sh_r;

	// ==================================================
	// Frame shifter: start bit, eight data bits LSB first, stop bit.
	always_ff @(posedge clk) begin
		if (srst) begin
			busy   <= 1'b0;
			txd    <= 1'b1;
			baud_r <= '0;
			bit_r  <= '0;
			sh_r   <= '1;
		end else if (!busy) begin
			if (req.start) begin
				busy   <= 1'b1;
				sh_r   <= {`UART_STOP_LVL, req.data, 1'b0};
				txd    <= 1'b0;
				baud_r <= CW'(CLKS_PER_BIT - 1);
				bit_r  <= '0;
			end
		end else if (baud_r != '0) begin
			baud_r <= baud_r - 1'b1;
		end else if (bit_r == `UART_FRAME_BITS) begin
			busy <= 1'b0;
			txd  <= 1'b1;
		end else begin
			sh_r   <= {1'b1, sh_r[9:1]};
			txd    <= sh_r[1];
			bit_r  <= bit_r + 1'b1;
			baud_r <= CW'(CLKS_PER_BIT - 1);
		end
	end

endmodule : uart_byte_tx

// ===== design/uart_boot_format_handler.sv
`include "boot_fmt_cfg.svh"

// Behaviour
// [RULE1] Sustained break at reset enters command mode.
// [RULE2] Host holds receive line spacing through reset.
// [RULE3] Any reset, cold or warm, senses break.
// [RULE4] Entering command mode sends 0x00 then 0xCC.
// [RULE5] No format within five seconds: boot normally.
// [RULE6] Host releases break, flushes, then sends.
// [RULE7] Host sends string matching flash capacity.
// [RULE8] Format finished: send 0x00 then 0xCC again.
// [RULE9] Formatting reachable only through this boot sequence.
// [RULE10] Fixed-baud framed bytes; unknown strings silently ignored.
module uart_boot_format_handler #(
	parameter int CLKS_PER_BIT   = `CLK_HZ / `BAUD_RATE,
	parameter int BREAK_CYCLES   = `BREAK_MIN_US * (`CLK_HZ / `US_PER_S),
	parameter int TIMEOUT_CYCLES = `CMD_TIMEOUT_S * `CLK_HZ
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       rxd,
	input  wire logic       fmt_done,
	output logic            txd,
	output logic            cmd_mode,
	output logic            fmt_req,
	output logic [7:0]      fmt_size,
	output logic            init_normal
);
	import boot_fmt_pkg::*;

	localparam int BW  = $clog2(BREAK_CYCLES + 1);
	localparam int TW  = $clog2(TIMEOUT_CYCLES + 1);
	localparam int CW  = $clog2(CLKS_PER_BIT + 1);
	localparam int FIW = $clog2(`FMT_LEN + 1);
	localparam int GAP_MAX = `ACK_GAP_BITS * CLKS_PER_BIT + `ACK_GAP_SLACK;
	localparam int GW  = $clog2(GAP_MAX + 1);

	boot_state_t   state_r;
	boot_state_t   state_nxt;
	logic [BW-1:0] brk_cnt_r;
	logic [TW-1:0] tmo_cnt_r;
	logic          released_r;
	tx_req_t       tx_req_r;
	logic          tx_busy;
	logic [1:0]    ack_cnt_r;
	logic [GW-1:0] ack_gap_r;
	logic          ack_fin;
	logic          break_seen;
	logic          tmo_end;
	logic          rx_on_r;
	logic [CW-1:0] rx_cnt_r;
	logic [3:0]    rx_bit_r;
	logic [7:0]    rx_sh_r;
	rx_byte_t      rx_out_r;
	logic [FIW-1:0] fmt_idx_r;
	logic [7:0]    size_exp_r;
	logic          byte_ok;
	logic [7:0]    cap_size;
	logic          fmt_hit;

	// ==================================================
	// Break sensing after every reset release.
	assign break_seen = (brk_cnt_r == BW'(BREAK_CYCLES - 1)) && !rxd;
	assign tmo_end    = (tmo_cnt_r == TW'(TIMEOUT_CYCLES - 1));
	assign ack_fin    = !tx_busy && !tx_req_r.start && (ack_cnt_r == `ACK_LEN);
	assign fmt_hit    = (state_r == ST_WAIT_CMD) && rx_out_r.vld && byte_ok &&
	                    (fmt_idx_r == FIW'(`FMT_LEN - 1));

	always_ff @(posedge clk) begin
		if (srst) begin
			brk_cnt_r <= '0;
		end else if (state_r == ST_SENSE && !rxd && !break_seen) begin
			brk_cnt_r <= brk_cnt_r + 1'b1; // [RULE1]
		end else begin
			brk_cnt_r <= '0;
		end
	end

	// ==================================================
	// Sequencer.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_SENSE: begin
				if (rxd) begin
					state_nxt = ST_NORMAL;
				end else if (break_seen) begin
					state_nxt = ST_ACK_OPEN; // [RULE1]
				end
			end
			ST_ACK_OPEN: begin
				if (ack_fin) begin
					state_nxt = ST_WAIT_CMD;
				end
			end
			ST_WAIT_CMD: begin
				if (fmt_hit) begin
					state_nxt = ST_FORMAT;
				end else if (tmo_end) begin
					state_nxt = ST_NORMAL; // [RULE5]
				end
			end
			ST_FORMAT: begin
				if (fmt_done) begin
					state_nxt = ST_ACK_DONE; // [RULE8]
				end
			end
			ST_ACK_DONE: begin
				if (ack_fin) begin
					state_nxt = ST_NORMAL;
				end
			end
			ST_NORMAL: state_nxt = ST_NORMAL;
			default:   state_nxt = ST_SENSE;
		endcase
	end

	// A warm reset lands here exactly as power-on does.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= ST_SENSE; // [RULE3]
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_mode    <= 1'b0;
			fmt_req     <= 1'b0;
			init_normal <= 1'b0;
		end else begin
			cmd_mode    <= state_nxt inside {ST_ACK_OPEN, ST_WAIT_CMD, ST_FORMAT, ST_ACK_DONE};
			fmt_req     <= (state_nxt == ST_FORMAT); // [RULE9]
			init_normal <= (state_nxt == ST_NORMAL);
		end
	end

	// ==================================================
	// Acknowledgment pair.
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_req_r  <= '0;
			ack_cnt_r <= '0;
			ack_gap_r <= '0;
		end else begin
			tx_req_r.start <= 1'b0;
			ack_gap_r      <= (ack_cnt_r == `ACK_LEN - 2'h1) ? ack_gap_r + 1'b1 : '0;
			if (state_nxt != state_r) begin
				ack_cnt_r <= '0;
			end else if ((state_r == ST_ACK_OPEN || state_r == ST_ACK_DONE) &&
			             !tx_busy && !tx_req_r.start && ack_cnt_r != `ACK_LEN) begin
				tx_req_r.start <= 1'b1;
				tx_req_r.data  <= (ack_cnt_r == '0) ? `ACK_BYTE0 : `ACK_BYTE1; // [RULE4] [RULE8]
				ack_cnt_r      <= ack_cnt_r + 1'b1;
			end
		end
	end

	uart_byte_tx #(
		.CLKS_PER_BIT(CLKS_PER_BIT)
	) u_tx (
		.clk (clk),
		.srst(srst),
		.req (tx_req_r),
		.busy(tx_busy),
		.txd (txd)
	);

	// ==================================================
	// Command window timer and break release.
	always_ff @(posedge clk) begin
		if (srst || state_r != ST_WAIT_CMD) begin
			tmo_cnt_r  <= '0;
			released_r <= 1'b0;
		end else begin
			tmo_cnt_r <= tmo_cnt_r + 1'b1; // [RULE5]
			if (rxd) begin
				released_r <= 1'b1;
			end
		end
	end

	// ==================================================
	// Receiver. It stays off until the break is released, so that the
	// held spacing level is never taken for a stream of zero bytes.
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_on_r  <= 1'b0;
			rx_cnt_r <= '0;
			rx_bit_r <= '0;
			rx_sh_r  <= '0;
			rx_out_r <= '0;
		end else begin
			rx_out_r.vld <= 1'b0;
			if (!rx_on_r) begin
				if (state_r == ST_WAIT_CMD && released_r && !rxd) begin
					rx_on_r  <= 1'b1;
					rx_cnt_r <= CW'(CLKS_PER_BIT / 2);
					rx_bit_r <= '0;
				end
			end else if (rx_cnt_r != '0) begin
				rx_cnt_r <= rx_cnt_r - 1'b1;
			end else begin
				rx_cnt_r <= CW'(CLKS_PER_BIT - 1);
				rx_bit_r <= rx_bit_r + 1'b1;
				if (rx_bit_r == '0 && rxd) begin
					rx_on_r <= 1'b0;
				end else if (rx_bit_r == `UART_FRAME_BITS) begin
					rx_on_r       <= 1'b0;
					rx_out_r.vld  <= (rxd == `UART_STOP_LVL); // [RULE10]
					rx_out_r.data <= rx_sh_r;
				end else if (rx_bit_r != '0) begin
					rx_sh_r <= {rxd, rx_sh_r[7:1]};
				end
			end
		end
	end

	// ==================================================
	// Format string matcher.
	always_comb begin
		cap_size = `SIZE_0M5;
		byte_ok  = 1'b1;
		case (rx_out_r.data)
			`CAP_0M5: cap_size = `SIZE_0M5;
			`CAP_4M:  cap_size = `SIZE_4M;
			`CAP_8M:  cap_size = `SIZE_8M;
			`CAP_16M: cap_size = `SIZE_16M;
			default:  byte_ok = (fmt_idx_r != FIW'(`POS_CAP));
		endcase
		case (fmt_idx_r)
			FIW'(`POS_CAP):  byte_ok = byte_ok;
			FIW'(`POS_B1):   byte_ok = (rx_out_r.data == `FMT_B1);
			FIW'(`POS_B3):   byte_ok = (rx_out_r.data == `FMT_B3);
			FIW'(`POS_B7):   byte_ok = (rx_out_r.data == `FMT_B7);
			FIW'(`POS_SIZE): byte_ok = (rx_out_r.data == size_exp_r);
			default:         byte_ok = (rx_out_r.data == `FMT_FILL);
		endcase
	end

	// A wrong byte drops the partial string; the timer keeps running.
	always_ff @(posedge clk) begin
		if (srst) begin
			fmt_idx_r  <= '0;
			size_exp_r <= `SIZE_0M5;
			fmt_size   <= `SIZE_0M5;
		end else if (state_r == ST_WAIT_CMD && rx_out_r.vld) begin
			if (!byte_ok || fmt_hit) begin
				fmt_idx_r <= '0; // [RULE10]
			end else begin
				fmt_idx_r <= fmt_idx_r + 1'b1;
			end
			if (byte_ok && fmt_idx_r == FIW'(`POS_CAP)) begin
				size_exp_r <= cap_size;
			end
			if (fmt_hit) begin
				fmt_size <= size_exp_r;
			end
		end
	end

	// ==================================================
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_ack_first;
		tx_req_r.start && tx_req_r.data == `ACK_BYTE0;
	endsequence

	chk_break_enter: assert property ($rose(cmd_mode) |-> // [RULE1]
		$past(state_r) == ST_SENSE && $past(brk_cnt_r) == BW'(BREAK_CYCLES - 1))
		else $error("Command mode entered without full break.");
	chk_idle_normal: assert property (state_r == ST_SENSE && rxd |=> // [RULE1]
		state_r == ST_NORMAL ##1 init_normal)
		else $error("Idle line did not lead to normal start.");
	chk_reset_sense: assert property ($fell(srst) |-> state_r == ST_SENSE && !cmd_mode) // [RULE3]
		else $error("Reset did not return to break sensing.");
	chk_ack_order: assert property (ack_gap_r != GW'(GAP_MAX)) // [RULE4]
		else $error("Second acknowledgment byte missing.");
	chk_ack_begin: assert property ($rose(state_r == ST_ACK_OPEN) |-> ##1 s_ack_first) // [RULE4]
		else $error("Acknowledgment did not start with the zero byte.");
	chk_cmd_timeout: assert property (state_r == ST_WAIT_CMD && tmo_end && !fmt_hit |=> // [RULE5]
		state_r == ST_NORMAL)
		else $error("Command window did not expire on time.");
	chk_done_ack: assert property (state_r == ST_FORMAT && fmt_done |=> // [RULE8]
		state_r == ST_ACK_DONE ##1 s_ack_first)
		else $error("Format completion not acknowledged.");
	chk_fmt_source: assert property (fmt_req |-> // [RULE9]
		state_r == ST_FORMAT && $past(state_r) != ST_SENSE)
		else $error("Format request outside boot sequence.");
	chk_bad_ignored: assert property (state_r == ST_WAIT_CMD && rx_out_r.vld && !byte_ok |=> // [RULE10]
		fmt_idx_r == '0 && !fmt_req && !tx_req_r.start)
		else $error("Unknown string was not ignored.");

endmodule : uart_boot_format_handler

// ===== verif/host_uart_model.sv
// ==================================================
// Host end of the boot serial link.
module host_uart_model #(
	parameter int CLKS_PER_BIT = 8
) (
	input  wire logic clk,
	input  wire logic txd,
	output logic      rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_q[$];
	logic [7:0] sh;

	initial rxd = 1'b1;

	// A break is a steady low with no framing.
	task automatic set_line(input logic lvl);
		@(posedge clk);
		#1 rxd = lvl;
	endtask : set_line

	task automatic flush();
		got_q.delete();
	endtask : flush

	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			#1 rxd = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (CLKS_PER_BIT - 1) @(posedge clk);
		end
	endtask : send

	// Mid-bit sampling; a frame whose stop bit is low is dropped.
	initial forever begin
		@(negedge txd);
		repeat (CLKS_PER_BIT / 2) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			repeat (CLKS_PER_BIT) @(posedge clk);
			if (i < 8) sh[i] = txd;
		end
		if (txd === 1'b1) got_q.push_back(sh);
	end
endmodule : host_uart_model

// ===== verif/tb_top.sv
`include "boot_fmt_cfg.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CPB = 8;
	localparam int BRK = 20;
	localparam int TO  = 3000;
	logic       clk         = 1'b0;
	logic       srst        = 1'b1;
	logic       fmt_done    = 1'b0;
	logic       rxd;
	logic       txd;
	logic       cmd_mode;
	logic       fmt_req;
	logic [7:0] fmt_size;
	logic       init_normal;
	int         n_errors    = 0;
	int         comparisons = 0;
	logic [7:0] caps[4]     = '{`CAP_0M5, `CAP_4M, `CAP_8M, `CAP_16M};
	logic [7:0] sizes[4]    = '{`SIZE_0M5, `SIZE_4M, `SIZE_8M, `SIZE_16M};
	logic [7:0] fmt_str[13] = '{8'h00, 8'h17, 8'h00, 8'h28, 8'h00, 8'h00, 8'h00,
		8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	always #5 clk = ~clk;

	uart_boot_format_handler #(
		.CLKS_PER_BIT  (CPB),
		.BREAK_CYCLES  (BRK),
		.TIMEOUT_CYCLES(TO)
	) dut (
		.clk        (clk),
		.srst       (srst),
		.rxd        (rxd),
		.fmt_done   (fmt_done),
		.txd        (txd),
		.cmd_mode   (cmd_mode),
		.fmt_req    (fmt_req),
		.fmt_size   (fmt_size),
		.init_normal(init_normal)
	);

	host_uart_model #(.CLKS_PER_BIT(CPB)) u_host (.clk(clk), .txd(txd), .rxd(rxd));

	// ==================================================
	// Helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	function automatic logic pick(input int w);
		return (w == 0) ? cmd_mode : (w == 1) ? fmt_req : init_normal;
	endfunction : pick

	task automatic wait_hi(input int w, input int lim);
		int n;
		#1;
		n = 0;
		while (pick(w) !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
		check(pick(w), 1'b1);
	endtask : wait_hi

	task automatic take_ack();
		logic [7:0] exp_q[$];
		int         n;
		exp_q = '{`ACK_BYTE0, `ACK_BYTE1};
		n = 0;
		while (u_host.got_q.size() < 2 && n < 30 * CPB) begin
			tick(1);
			n++;
		end
		check(8'(u_host.got_q.size()), 8'h02);
		foreach (exp_q[i]) check(u_host.got_q[i], exp_q[i]);
		u_host.flush();
	endtask : take_ack

	task automatic do_reset(input logic brk);
		u_host.set_line(~brk);
		srst = 1'b1;
		tick(12);
		srst = 1'b0;
		check(txd, 1'b1);
		check(cmd_mode | init_normal | fmt_req, 1'b0);
	endtask : do_reset

	// The pause lets the ack frame end before the string starts.
	task automatic enter_cmd();
		do_reset(1'b1);
		wait_hi(0, BRK + 4);
		take_ack();
		u_host.set_line(1'b1);
		tick(2 * CPB);
	endtask : enter_cmd

	task automatic end_sim();
		$display("errors %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	always @(posedge clk) begin
		if (!srst && fmt_req === 1'b1 && cmd_mode !== 1'b1) check(1'b0, 1'b1);
	end

	initial begin
		tick(60000);
		n_errors++;
		end_sim();
	end

	// ==================================================
	// Tests
	initial begin
		logic [7:0] bad;
		void'($urandom(32'h7747a11b));
		for (int c = 0; c < 4; c++) begin
			enter_cmd();
			bad = 8'($urandom) | 8'h01;
			u_host.send(8'h00);
			u_host.send(`FMT_B1);
			u_host.send(bad);
			u_host.send(8'hFF);
			check(fmt_req, 1'b0);
			fmt_str[`POS_CAP] = caps[c];
			fmt_str[`POS_SIZE] = sizes[c];
			foreach (fmt_str[i]) u_host.send(fmt_str[i]);
			wait_hi(1, 4 * CPB);
			check(fmt_size, sizes[c]);
			check(8'(u_host.got_q.size()), 8'h00);
			tick(1 + $urandom_range(0, 20));
			fmt_done = 1'b1;
			tick(1);
			fmt_done = 1'b0;
			tick(1);
			check(fmt_req, 1'b0);
			take_ack();
			wait_hi(2, 4 * CPB);
			check(cmd_mode, 1'b0);
		end
		enter_cmd();
		tick(TO - 40 * CPB);
		check(cmd_mode, 1'b1);
		wait_hi(2, 60 * CPB);
		check(cmd_mode, 1'b0);
		check(8'(u_host.got_q.size()), 8'h00);
		do_reset(1'b0);
		wait_hi(2, 4);
		check(cmd_mode, 1'b0);
		end_sim();
	end
endmodule : tb_top
